/* design/return_instruction_unit.sv */
// Contract
// - the interrupt return opcode is 0000 0000 0001 000s with s as the fast-restore flag.
// - an interrupt return pops the return stack and loads the popped top into the pc.
// - an interrupt return sets the high or low priority global enable and leaves the other enable unchanged.
// - interrupt return with s=1 copies the three shadows into accumulator, flags and bank select.
// - interrupt return is one word, two cycles, pop and enable set in phase four, second cycle idle.
// - no return instruction touches the pc upper or high latch.
// - opcode 0000 1100 kkkk kkkk is a literal return that writes k into the accumulator.
// - literal return pops into the pc in the same phase the accumulator is written, two cycles.
// - opcode 0000 0000 0001 001s is a subroutine return that pops into the pc, flags untouched when s=0.
// - subroutine return with s=1 reloads accumulator, flags and bank select from shadows.
// - each pop from a non-empty stack makes the entry pushed before the discarded top the new top; a pop on an empty stack loads zero.
`timescale 1ns/10ps
`include "rtu_params.svh"

module return_instruction_unit #(
	parameter int PC_WIDTH    = `RTU_PC_WIDTH,
	parameter int STACK_DEPTH = `RTU_STACK_DEPTH
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	// instruction word presented at the start of each instruction cycle
	input  wire logic [15:0]           instrWord,
	input  wire logic                  instrValid,
	// priority level being returned to: 1 high, 0 low
	input  wire logic                  irqHighLevel,
	// push from the rest of the core
	input  wire logic                  pushReq,
	input  wire logic [PC_WIDTH-1:0]   pushValue,
	// shadow copies
	input  wire logic [7:0]            accumulatorShadow,
	input  wire logic [7:0]            flagShadow,
	input  wire logic [7:0]            bankSelectShadow,
	output logic [PC_WIDTH-1:0]        pcOut,
	output logic [PC_WIDTH-1:0]        stackTop,
	output logic [7:0]                 accumulator,
	output logic [7:0]                 flags,
	output logic [7:0]                 bankSelectLatch,
	output logic                       highPrioGlobalEnable,
	output logic                       lowPrioGlobalEnable,
	output logic                       retBusy,
	output logic                       pcLoad,
	output logic                       flushPrefetch
);

	localparam int PTR_W = $clog2(STACK_DEPTH + 1);

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------

	function automatic rtu_pkg::rtu_op_t decodeOp(input logic [15:0] w);
		rtu_pkg::rtu_op_t op;
		op = rtu_pkg::RTU_OP_NONE;
		if (w[15:1] == `RTU_OP_IRET_HI) begin
			op = rtu_pkg::RTU_OP_IRET;
		end else if (w[15:1] == `RTU_OP_SRET_HI) begin
			op = rtu_pkg::RTU_OP_SRET;
		end else if (w[15:8] == `RTU_OP_LRET_HI) begin
			op = rtu_pkg::RTU_OP_LRET;
		end
		return op;
	endfunction : decodeOp

	rtu_pkg::rtu_phase_t phase;
	logic                cycleEnd;

	rtu_phase_gen u_phase (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.phase    (phase),
		.cycleEnd (cycleEnd)
	);

	rtu_pkg::rtu_state_t state_q;
	rtu_pkg::rtu_op_t    op_q;
	logic                fast_q;
	logic [7:0]          literal_q;

	wire logic atQ1 = (phase == rtu_pkg::RTU_PH_Q1);
	wire logic atQ2 = (phase == rtu_pkg::RTU_PH_Q2);
	wire logic atQ4 = (phase == rtu_pkg::RTU_PH_Q4);

	// --------------------------------------------------------------
	// instruction sequencing
	// --------------------------------------------------------------

	// capture the opcode at q1 of an executing cycle; flush cycle ignores input
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			op_q   <= rtu_pkg::RTU_OP_NONE;
			fast_q <= 1'b0;
		end else if (atQ1) begin
			if (state_q == rtu_pkg::RTU_ST_EXEC && instrValid) begin
				op_q   <= decodeOp(instrWord);
				fast_q <= instrWord[`RTU_FAST_BIT];
			end else begin
				op_q   <= rtu_pkg::RTU_OP_NONE;
				fast_q <= 1'b0;
			end
		end
	end

	// literal is read in q2 of the first cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			literal_q <= 8'h00;
		end else if (atQ2 && op_q == rtu_pkg::RTU_OP_LRET) begin
			literal_q <= instrWord[7:0];
		end
	end

	wire logic retQ4 = atQ4 && state_q == rtu_pkg::RTU_ST_EXEC
		&& op_q != rtu_pkg::RTU_OP_NONE;

	// second cycle of every return is a no-operation slot
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= rtu_pkg::RTU_ST_EXEC;
		end else if (cycleEnd) begin
			unique case (state_q)
				rtu_pkg::RTU_ST_EXEC:  if (retQ4) state_q <= rtu_pkg::RTU_ST_FLUSH;
				rtu_pkg::RTU_ST_FLUSH: state_q <= rtu_pkg::RTU_ST_EXEC;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			retBusy       <= 1'b0;
			flushPrefetch <= 1'b0;
		end else begin
			// drops at the last edge of the no-op cycle so busy spans four clocks
			retBusy       <= (state_q == rtu_pkg::RTU_ST_FLUSH && !cycleEnd) || retQ4;
			flushPrefetch <= retQ4;
		end
	end

	// --------------------------------------------------------------
	// return stack
	// --------------------------------------------------------------

	// array holds entries below the top; top sits in its own register
	logic [PC_WIDTH-1:0] stackMem [STACK_DEPTH];
	logic [PTR_W-1:0]    depth_q;
	logic [PC_WIDTH-1:0] top_q;

	wire logic doPop  = retQ4;
	wire logic doPush = pushReq && !doPop;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			depth_q <= '0;
			top_q   <= '0;
		end else if (doPop) begin
			// entry pushed before the discarded top becomes the new top; an empty stack pops to zero
			if (depth_q != '0) begin
				top_q   <= stackMem[PTR_W'(depth_q - 1'b1)];
				depth_q <= PTR_W'(depth_q - 1'b1);
			end else begin
				top_q <= '0;
			end
		end else if (doPush) begin
			top_q <= pushValue;
			// a push on a full stack overwrites the top; older entries are kept
			if (depth_q != PTR_W'(STACK_DEPTH)) begin
				depth_q <= PTR_W'(depth_q + 1'b1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (doPush && depth_q != PTR_W'(STACK_DEPTH)) begin
			stackMem[depth_q] <= top_q;
		end
	end

	// --------------------------------------------------------------
	// program counter; latches are outside and never driven here
	// --------------------------------------------------------------

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pcOut  <= PC_WIDTH'(`RTU_PC_RESET);
			pcLoad <= 1'b0;
		end else begin
			pcLoad <= doPop;
			if (doPop) begin
				pcOut <= top_q;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stackTop <= '0;
		end else begin
			stackTop <= top_q;
		end
	end

	// --------------------------------------------------------------
	// register file writes
	// --------------------------------------------------------------

	wire logic fastRestore = retQ4 && fast_q
		&& (op_q == rtu_pkg::RTU_OP_IRET || op_q == rtu_pkg::RTU_OP_SRET);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			accumulator     <= 8'h00;
			flags           <= 8'h00;
			bankSelectLatch <= 8'h00;
		end else if (fastRestore) begin
			accumulator     <= accumulatorShadow;
			flags           <= flagShadow;
			bankSelectLatch <= bankSelectShadow;
		end else if (retQ4 && op_q == rtu_pkg::RTU_OP_LRET) begin
			accumulator <= literal_q;
		end
	end

	// the global enables change only on interrupt return
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			highPrioGlobalEnable <= 1'b0;
			lowPrioGlobalEnable  <= 1'b0;
		end else if (retQ4 && op_q == rtu_pkg::RTU_OP_IRET) begin
			if (irqHighLevel) begin
				highPrioGlobalEnable <= 1'b1;
			end else begin
				lowPrioGlobalEnable <= 1'b1;
			end
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------

	property p_iretDecode;
		@(posedge clk_sys) disable iff (rst)
		(atQ1 && state_q == rtu_pkg::RTU_ST_EXEC && instrValid
			&& instrWord[15:1] == 15'h0008) |=> (op_q == rtu_pkg::RTU_OP_IRET);
	endproperty
	a_iretDecode: assert property (p_iretDecode) else $error("iret not decoded");

	property p_popToPc;
		@(posedge clk_sys) disable iff (rst)
		retQ4 |=> (pcOut == $past(top_q) && pcLoad);
	endproperty
	a_popToPc: assert property (p_popToPc) else $error("pc not loaded from top");

	property p_enableSet;
		@(posedge clk_sys) disable iff (rst)
		(retQ4 && op_q == rtu_pkg::RTU_OP_IRET)
			|=> ($past(irqHighLevel) ? highPrioGlobalEnable : lowPrioGlobalEnable);
	endproperty
	a_enableSet: assert property (p_enableSet) else $error("global enable not set");

	property p_fastRestore;
		@(posedge clk_sys) disable iff (rst)
		fastRestore |=> (flags == $past(flagShadow) && bankSelectLatch == $past(bankSelectShadow));
	endproperty
	a_fastRestore: assert property (p_fastRestore) else $error("shadow not restored");

	property p_noRestore;
		@(posedge clk_sys) disable iff (rst)
		(retQ4 && !fast_q) |=> $stable(flags) && $stable(bankSelectLatch);
	endproperty
	a_noRestore: assert property (p_noRestore) else $error("flags changed without s");

	property p_twoCycles;
		@(posedge clk_sys) disable iff (rst)
		retQ4 |=> retBusy [*4] ##1 !retBusy;
	endproperty
	a_twoCycles: assert property (p_twoCycles) else $error("return not two cycles");

	property p_literal;
		@(posedge clk_sys) disable iff (rst)
		(retQ4 && op_q == rtu_pkg::RTU_OP_LRET) |=> (accumulator == $past(literal_q) && pcLoad);
	endproperty
	a_literal: assert property (p_literal) else $error("literal not written with pop");

	property p_popDepth;
		@(posedge clk_sys) disable iff (rst)
		(doPop && depth_q != '0) |=> (depth_q == $past(depth_q) - 1'b1);
	endproperty
	a_popDepth: assert property (p_popDepth) else $error("pop did not drop depth");

	property p_flushIdle;
		@(posedge clk_sys) disable iff (rst)
		(atQ1 && state_q == rtu_pkg::RTU_ST_FLUSH) |=> (op_q == rtu_pkg::RTU_OP_NONE);
	endproperty
	a_flushIdle: assert property (p_flushIdle) else $error("work in no-op slot");

	c_iret: cover property (@(posedge clk_sys) retQ4 && op_q == rtu_pkg::RTU_OP_IRET && fast_q);
	c_lret: cover property (@(posedge clk_sys) retQ4 && op_q == rtu_pkg::RTU_OP_LRET);
	c_sret: cover property (@(posedge clk_sys) retQ4 && op_q == rtu_pkg::RTU_OP_SRET);

endmodule : return_instruction_unit

/* design/rtu_params.svh */
`ifndef RTU_PARAMS_SVH
`define RTU_PARAMS_SVH

// opcode patterns (upper bits, without the fast-restore bit or literal)
`define RTU_OP_IRET_HI     15'h0008
`define RTU_OP_SRET_HI     15'h0009
`define RTU_OP_LRET_HI     8'h0c
`define RTU_FAST_BIT       0

// program counter reset value
`define RTU_PC_RESET       21'h000000
`define RTU_PC_WIDTH       21
`define RTU_STACK_DEPTH    31
`define RTU_PHASES         4

`endif

/* design/rtu_pkg.sv */
package rtu_pkg;

	typedef enum logic [1:0] {
		RTU_PH_Q1,
		RTU_PH_Q2,
		RTU_PH_Q3,
		RTU_PH_Q4
	} rtu_phase_t;

	typedef enum logic [1:0] {
		RTU_OP_NONE,
		RTU_OP_IRET,
		RTU_OP_LRET,
		RTU_OP_SRET
	} rtu_op_t;

	typedef enum {
		RTU_ST_EXEC,
		RTU_ST_FLUSH
	} rtu_state_t;

endpackage : rtu_pkg

/* design/rtu_phase_gen.sv */
`timescale 1ns/10ps
`include "rtu_params.svh"

// four-phase sequencer: one instruction cycle is four clk_sys edges
module rtu_phase_gen (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	output rtu_pkg::rtu_phase_t    phase,
	output logic                   cycleEnd
);

	rtu_pkg::rtu_phase_t phase_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phase_q <= rtu_pkg::RTU_PH_Q1;
		end else begin
			unique case (phase_q)
				rtu_pkg::RTU_PH_Q1: phase_q <= rtu_pkg::RTU_PH_Q2;
				rtu_pkg::RTU_PH_Q2: phase_q <= rtu_pkg::RTU_PH_Q3;
				rtu_pkg::RTU_PH_Q3: phase_q <= rtu_pkg::RTU_PH_Q4;
				rtu_pkg::RTU_PH_Q4: phase_q <= rtu_pkg::RTU_PH_Q1;
			endcase
		end
	end

	assign phase    = phase_q;
	assign cycleEnd = (phase_q == rtu_pkg::RTU_PH_Q4);

endmodule : rtu_phase_gen

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	typedef struct {
		int          at;
		logic [20:0] pc;
		logic [20:0] top;
		logic [7:0]  acc;
		logic [7:0]  flg;
		logic [7:0]  bank_select_latch;
		logic        hi;
		logic        lo;
	} rtu_exp_t;

	logic        clk_sys;
	logic        rst;
	logic [15:0] instrWord;
	logic        instrValid;
	logic        irqHighLevel;
	logic        pushReq;
	logic [20:0] pushValue;
	logic [7:0]  accumulatorShadow;
	logic [7:0]  flagShadow;
	logic [7:0]  bankSelectShadow;
	logic [20:0] pcOut;
	logic [20:0] stackTop;
	logic [7:0]  accumulator;
	logic [7:0]  flags;
	logic [7:0]  bankSelectLatch;
	logic        highPrioGlobalEnable;
	logic        lowPrioGlobalEnable;
	logic        retBusy;
	logic        pcLoad;
	logic        flushPrefetch;
	logic [20:0] stk[$];
	rtu_exp_t    expQ[$];
	rtu_exp_t    m;
	rtu_exp_t    e;
	logic        skip;
	int          cyc = 0;
	int          err_count = 0;
	int          checks = 0;
	logic [15:0] ret_nr[6] = '{16'h0000, 16'h0018, 16'h0014, 16'h0d5a, 16'h0006, 16'h0e12};

	return_instruction_unit u_dut (
		.clk_sys              (clk_sys),
		.rst                  (rst),
		.instrWord            (instrWord),
		.instrValid           (instrValid),
		.irqHighLevel         (irqHighLevel),
		.pushReq              (pushReq),
		.pushValue            (pushValue),
		.accumulatorShadow    (accumulatorShadow),
		.flagShadow           (flagShadow),
		.bankSelectShadow     (bankSelectShadow),
		.pcOut                (pcOut),
		.stackTop             (stackTop),
		.accumulator          (accumulator),
		.flags                (flags),
		.bankSelectLatch      (bankSelectLatch),
		.highPrioGlobalEnable (highPrioGlobalEnable),
		.lowPrioGlobalEnable  (lowPrioGlobalEnable),
		.retBusy              (retBusy),
		.pcLoad               (pcLoad),
		.flushPrefetch        (flushPrefetch)
	);

	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	// sampled by every process before the edge updates it, so all agree on the count
	always @(posedge clk_sys) cyc <= cyc + 1;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	function logic [20:0] topOf();
		return stk.size() ? stk[0] : 21'h000000;
	endfunction : topOf

	function logic [15:0] ret(input int r);
		case (r % 5)
			0: ret = 16'h0010;
			1: ret = 16'h0011;
			2: ret = 16'h0012;
			3: ret = 16'h0013;
			default: ret = {8'h0c, 8'($urandom)};
		endcase
	endfunction : ret

	task do_reset();
		rst <= 1'h1;
		pushReq <= 1'h0;
		instrValid <= 1'h0;
		repeat (2) @(posedge clk_sys);
		chk("reset pc", pcOut, 32'h0);
		chk("reset acc", accumulator, 32'h0);
		chk("reset flags", {highPrioGlobalEnable, lowPrioGlobalEnable, retBusy, pcLoad}, 32'h0);
		rst <= 1'h0;
		stk.delete();
		m = '{default: 0};
		skip = 1'h0;
	endtask : do_reset

	// one instruction cycle: word sampled at the next edge (phase one), pushes on its edges
	task slot(input logic [15:0] w, input logic v, input int np);
		logic [7:0]  a;
		logic [7:0]  f;
		logic [7:0]  b;
		logic        h;
		logic [20:0] pv;
		logic [1:0]  k;
		a = 8'($urandom);
		f = 8'($urandom);
		b = 8'($urandom);
		h = 1'($urandom);
		k = (!v || skip) ? 2'h0 : (w[15:1] == 15'h0008) ? 2'h1 :
			(w[15:1] == 15'h0009) ? 2'h3 : (w[15:8] == 8'h0c) ? 2'h2 : 2'h0;
		instrWord <= w;
		instrValid <= v;
		irqHighLevel <= h;
		accumulatorShadow <= a;
		flagShadow <= f;
		bankSelectShadow <= b;
		if (k != 2'h0) begin
			if (k == 2'h1 && h) m.hi = 1'h1;
			if (k == 2'h1 && !h) m.lo = 1'h1;
			if (k == 2'h2) m.acc = w[7:0];
			else if (w[0]) begin
				m.acc = a;
				m.flg = f;
				m.bank_select_latch = b;
			end
			m.pc = topOf();
			if (stk.size() > 0) void'(stk.pop_front());
			m.top = topOf();
			m.at = cyc + 5;
			expQ.push_back(m);
		end
		skip = (k != 2'h0);
		for (int i = 0; i < 4; i++) begin
			pv = 21'($urandom);
			pushReq <= (i < np);
			pushValue <= pv;
			// a full stack keeps its depth and takes the push as its new top
			if (i < np && stk.size() < 31) stk.push_front(pv);
			else if (i < np) stk[0] = pv;
			@(posedge clk_sys);
		end
	endtask : slot

	task endt(input string nm);
		$display("test %s done, mismatches so far %0d", nm, err_count);
	endtask : endt

	task finish_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// ---------------------------------------------------------------
	// output watcher
	// ---------------------------------------------------------------
	initial forever begin
		@(posedge clk_sys);
		if (rst === 1'h0 && pcLoad !== 1'h0) begin
			if (expQ.size() == 0) chk("unexpected load", 32'h1, 32'h0);
			else begin
				e = expQ.pop_front();
				chk("load cycle", cyc, e.at);
				chk("pc", pcOut, e.pc);
				chk("flush", flushPrefetch, 32'h1);
				chk("acc", accumulator, e.acc);
				chk("flags bank", {flags, bankSelectLatch}, {e.flg, e.bank_select_latch});
				chk("enables", {highPrioGlobalEnable, lowPrioGlobalEnable}, {e.hi, e.lo});
				@(posedge clk_sys);
				chk("load pulse", {pcLoad, flushPrefetch, retBusy}, 32'h1);
				repeat (2) @(posedge clk_sys);
				chk("stack top", stackTop, e.top);
				chk("busy", retBusy, 32'h1);
				@(posedge clk_sys);
				chk("busy end", retBusy, 32'h0);
			end
		end
	end

	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		rst = 1'h1;
		instrWord = 16'h0000;
		instrValid = 1'h0;
		irqHighLevel = 1'h0;
		pushReq = 1'h0;
		pushValue = 21'h000000;
		accumulatorShadow = 8'h00;
		flagShadow = 8'h00;
		bankSelectShadow = 8'h00;
		skip = 1'h0;
		void'($urandom(48558));
		@(posedge clk_sys);
		do_reset();
		slot(16'h0000, 1'h1, 3);
		slot(16'h0000, 1'h1, 3);
		// every return kind, each shadowed by a return word in its idle cycle
		for (int r = 0; r < 5; r++) begin
			slot(ret(r), 1'h1, 0);
			slot(ret(r + 1), 1'h1, 0);
		end
		endt("return kinds");
		foreach (ret_nr[i]) slot(ret_nr[i], 1'h1, 1);
		slot(16'h0013, 1'h0, 1);
		slot(16'h0012, 1'h1, 0);
		slot(16'h0000, 1'h1, 0);
		endt("non returns");
		// overflow the stack, then pop past empty
		repeat (8) slot(16'h0000, 1'h1, 4);
		for (int r = 0; r < 33; r++) begin
			slot(ret(r), 1'h1, 0);
			slot(16'h0000, 1'h1, 0);
		end
		endt("full and empty");
		slot(16'h0000, 1'h1, 2);
		do_reset();
		slot(16'h0011, 1'h1, 0);
		slot(16'h0000, 1'h1, 0);
		endt("mid run reset");
		repeat (12) @(posedge clk_sys);
		while (expQ.size() > 0) begin
			chk("missing load", 32'h1, 32'h0);
			void'(expQ.pop_front());
		end
		finish_test();
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		chk("timeout", 32'h1, 32'h0);
		finish_test();
	end
endmodule : tb_top
